/* File: rtl/cio_cpu_end.sv */
// processor end: cpu pseudo-device, skip tests, mask, interrupt gating
// assumes instruction words from the core on clk_sys; pins are asynchronous
`timescale 1ns/100ps
`include "cio_defines.svh"
module cio_cpu_end import cio_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   cio_if.cpu io,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] acc_in,
   input wire logic instr_start,
   input wire logic start_interruptible,
   input wire logic instr_retire,
   input wire logic retire_one_cycle,
   input wire logic [15:0] vc_register,
   input wire logic vc_reset_cmd,
   input wire logic halt_continue,
   input wire logic power_fail_pin,
   input wire logic break_key_pin,
   input wire logic load_key_pin,
   input wire logic halt_strap_pin,
   input wire logic single_step_pin,
   input wire logic mem_retained_pin,
   input wire logic loop_test_pin,
   input wire logic [1:0] mem_size_pin,
   input wire logic reset_switch_pin,
   input wire logic console_locked_pin,
   output logic instr_done,
   output logic [15:0] acc_out,
   output logic acc_write,
   output logic skip_next,
   output logic cpu_halted,
   output logic console_entry,
   output logic interrupt_allowed
);
   logic [`CIO_NPIN-1:0] pin_raw, pin_m, pin_s;
   logic power_loss_flag, break_s, load_key_event, halt_routing_select, single_step_mode;
   logic memory_retained_valid, console_loop_test, rsw_s, lock_s, break_q, rsw_q;
   logic [1:0] memory_size_code;
   cio_bus_state_t state;
   cio_delay_state_t dly;
   logic interrupts_on_flag, next_ion, break_key_event, power_up_event, halt_executed;
   logic powerup_pending, is_cpu, take, local_exec, reset_all, cpu_skip, dev_skip;
   logic console_ack;
   logic [15:0] interrupt_priority_mask, cpu_status_word;
   logic [2:0] tmo, op;
   logic [1:0] fn, ac;
   logic [5:0] dev;

   // pin synchronisers
   assign pin_raw = {power_fail_pin, break_key_pin, load_key_pin, halt_strap_pin,
      single_step_pin, mem_retained_pin, loop_test_pin, mem_size_pin,
      reset_switch_pin, console_locked_pin};

   genvar g;
   for (g = 0; g < `CIO_NPIN; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            pin_m[g] <= 1'b0;
            pin_s[g] <= 1'b0;
         end else if (ce) begin
            pin_m[g] <= pin_raw[g];
            pin_s[g] <= pin_m[g];
         end
      end
   end

   assign {power_loss_flag, break_s, load_key_event, halt_routing_select,
      single_step_mode, memory_retained_valid, console_loop_test, memory_size_code,
      rsw_s, lock_s} = pin_s;

   // instruction decode
   assign op = instr_word[`CIO_W_OP_HI:`CIO_W_OP_LO];
   assign fn = instr_word[`CIO_W_F_HI:`CIO_W_F_LO];
   assign ac = instr_word[`CIO_W_AC_HI:`CIO_W_AC_LO];
   assign dev = instr_word[`CIO_W_DEV_HI:`CIO_W_DEV_LO];
   assign is_cpu = (dev == `CIO_DEV_CPU);
   assign take = ce && state == CIO_IDLE && instr_valid && !cpu_halted;
   assign local_exec = take && is_cpu;
   assign console_ack = local_exec && op == `CIO_OP_DOA && fn == `CIO_F_PULSE;

   // power-up, unlocked reset switch, console reset command
   assign reset_all = ce && (powerup_pending || (rsw_s && !rsw_q && !lock_s) ||
      vc_reset_cmd);

   assign cpu_status_word = {power_loss_flag, interrupts_on_flag, 1'b1, break_key_event,
      power_up_event, halt_executed, halt_routing_select, io.irq_req, load_key_event,
      1'b0, single_step_mode, memory_retained_valid, memory_size_code, 1'b0,
      console_loop_test};

   // low test bit inverts, high bit picks the flag
   assign cpu_skip = fn[0] ^ (fn[1] ? power_loss_flag : interrupts_on_flag);
   assign dev_skip = io.io_func[0] ^ (io.io_func[1] ? io.rsp_done : io.rsp_busy);

   // interrupts-on flag after a cpu operation other than skip or DOA: 01 sets, 10 clears
   assign next_ion = (op == `CIO_OP_SKP || op == `CIO_OP_DOA || fn[0] == fn[1]) ?
      interrupts_on_flag : fn[0];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         powerup_pending <= 1'b1;
         break_q <= 1'b0;
         rsw_q <= 1'b0;
      end else if (ce) begin
         powerup_pending <= 1'b0;
         break_q <= break_s;
         rsw_q <= rsw_s;
      end
   end

   // only the interrupts-on flag is cleared; no float status lives here
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         interrupts_on_flag <= 1'b0;
      end else if (reset_all) begin
         interrupts_on_flag <= 1'b0;
      end else if (local_exec) begin
         interrupts_on_flag <= next_ion;
      end
   end

   // priority mask, write-only from software
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         interrupt_priority_mask <= `CIO_MASK_RESET;
      end else if (local_exec && op == `CIO_OP_DOB) begin
         interrupt_priority_mask <= acc_in;
      end else if (local_exec && op == `CIO_OP_DIC) begin
         interrupt_priority_mask <= `CIO_MASK_RESET;
      end
   end

   // console events; a new event wins over the acknowledge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         break_key_event <= 1'b0;
         power_up_event <= 1'b0;
         halt_executed <= 1'b0;
      end else if (ce) begin
         if (console_ack) begin
            break_key_event <= 1'b0;
            power_up_event <= 1'b0;
            halt_executed <= 1'b0;
         end
         if (break_s && !break_q) break_key_event <= 1'b1;
         if (powerup_pending) power_up_event <= 1'b1;
         if (local_exec && op == `CIO_OP_DOC) halt_executed <= 1'b1;
      end
   end

   // halt: routed to console or processor stop
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cpu_halted <= 1'b0;
         console_entry <= 1'b0;
      end else if (ce) begin
         console_entry <= local_exec && op == `CIO_OP_DOC && halt_routing_select;
         if (local_exec && op == `CIO_OP_DOC && !halt_routing_select) begin
            cpu_halted <= 1'b1;
         end else if (halt_continue) begin
            cpu_halted <= 1'b0;
         end
      end
   end

   // enable delay after the flag rises
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dly <= CIO_DLY_OPEN;
      end else if (ce) begin
         if (local_exec && !interrupts_on_flag && next_ion && !reset_all) begin
            dly <= CIO_DLY_FIRST;
         end else if (instr_retire) begin
            unique case (dly)
               CIO_DLY_FIRST: dly <= retire_one_cycle ? CIO_DLY_SECOND : CIO_DLY_OPEN;
               CIO_DLY_SECOND: dly <= CIO_DLY_OPEN;
               CIO_DLY_OPEN: dly <= CIO_DLY_OPEN;
            endcase
         end
      end
   end

   // halted processor ignores program interrupts
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         interrupt_allowed <= 1'b0;
      end else if (ce) begin
         interrupt_allowed <= interrupts_on_flag && io.irq_req && !cpu_halted &&
            (dly == CIO_DLY_OPEN ||
            (dly == CIO_DLY_FIRST && instr_start && start_interruptible));
      end
   end

   // bus sequencing toward the controllers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= CIO_IDLE;
         tmo <= 3'h0;
         io.io_strobe <= 1'b0;
         io.io_op <= `CIO_OP_NIO;
         io.io_func <= `CIO_F_NONE;
         io.io_dev <= `CIO_DEV_NONE;
         io.io_wdata <= 16'h0000;
         io.io_reset <= 1'b0;
         io.io_mask <= `CIO_MASK_RESET;
      end else if (ce) begin
         io.io_reset <= reset_all;
         io.io_mask <= interrupt_priority_mask;
         io.io_strobe <= take && (!is_cpu || op == `CIO_OP_DOB || op == `CIO_OP_DIC ||
            op == `CIO_OP_DIB);
         if (take) begin
            io.io_op <= op;
            io.io_func <= fn;
            io.io_dev <= dev;
            io.io_wdata <= acc_in;
         end
         unique case (state)
            CIO_IDLE: begin
               tmo <= 3'h0;
               if (take && !is_cpu) state <= CIO_WAIT;
            end
            CIO_WAIT: begin
               tmo <= tmo + 3'h1;
               if (io.rsp_valid || tmo == `CIO_IO_TIMEOUT) state <= CIO_IDLE;
            end
         endcase
      end
   end

   // results toward the core
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         instr_done <= 1'b0;
         acc_out <= 16'h0000;
         acc_write <= 1'b0;
         skip_next <= 1'b0;
      end else if (ce) begin
         instr_done <= 1'b0;
         acc_write <= 1'b0;
         skip_next <= 1'b0;
         if (local_exec) begin
            instr_done <= 1'b1;
            unique case (op)
               `CIO_OP_DIA: begin
                  acc_out <= vc_register;
                  acc_write <= 1'b1;
               end
               `CIO_OP_DIB: begin
                  acc_out <= {`CIO_ACK_FILL, io.irq_code};
                  acc_write <= 1'b1;
               end
               `CIO_OP_SKP: begin
                  if (ac != 2'h0) begin
                     acc_out <= cpu_status_word;
                     acc_write <= 1'b1;
                  end else begin
                     skip_next <= cpu_skip;
                  end
               end
               default: ;
            endcase
         end else if (state == CIO_WAIT && (io.rsp_valid || tmo == `CIO_IO_TIMEOUT)) begin
            instr_done <= 1'b1;
            if (io.io_op == `CIO_OP_SKP) begin
               skip_next <= io.rsp_valid && dev_skip;
            end else if (io.io_op inside {`CIO_OP_DIA, `CIO_OP_DIB, `CIO_OP_DIC}) begin
               acc_out <= io.rsp_valid ? io.rsp_rdata : `CIO_NODEV_DATA;
               acc_write <= 1'b1;
            end
         end
      end
   end
endmodule : cio_cpu_end

/* File: rtl/cio_ctl_end.sv */
// one device controller on the programmed I/O bus
// assumes the processor end drives strobes for one cycle
`timescale 1ns/100ps
`include "cio_defines.svh"
module cio_ctl_end import cio_pkg::*; #(
   parameter logic [5:0] DEV_CODE = 6'h0A,
   parameter int MASK_BIT = 14
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   cio_if.ctl io,
   input wire logic dev_finish,
   input wire logic [15:0] in_a,
   input wire logic [15:0] in_b,
   input wire logic [15:0] in_c,
   output logic [15:0] out_data,
   output logic [2:0] out_load,
   output logic dev_pulse,
   output logic dev_busy,
   output logic dev_done
);
   localparam int MIDX = 15 - MASK_BIT;

   logic addressed;
   logic bcast_reset;

   assign addressed = io.io_strobe && (io.io_dev == DEV_CODE);
   // a cpu-addressed input c is the reset-all broadcast
   assign bcast_reset = io.io_reset ||
      (io.io_strobe && io.io_dev == `CIO_DEV_CPU && io.io_op == `CIO_OP_DIC);

   // busy and done; completion wins over any clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dev_busy <= 1'b0;
         dev_done <= 1'b0;
      end else if (ce) begin
         if (bcast_reset) begin
            dev_busy <= 1'b0;
            dev_done <= 1'b0;
         end else if (addressed && io.io_op != `CIO_OP_SKP) begin
            unique case (io.io_func)
               `CIO_F_START: begin
                  dev_busy <= 1'b1;
                  dev_done <= 1'b0;
               end
               `CIO_F_CLEAR: begin
                  dev_busy <= 1'b0;
                  dev_done <= 1'b0;
               end
               `CIO_F_NONE, `CIO_F_PULSE: begin
               end
            endcase
         end
         if (dev_finish) begin
            dev_busy <= 1'b0;
            dev_done <= 1'b1;
         end
      end
   end

   // answer to an addressed transfer, flags as before the function
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         io.rsp_valid <= 1'b0;
         io.rsp_busy <= 1'b0;
         io.rsp_done <= 1'b0;
         io.rsp_rdata <= 16'h0000;
      end else if (ce) begin
         io.rsp_valid <= addressed;
         io.rsp_busy <= dev_busy;
         io.rsp_done <= dev_done;
         unique case (io.io_op)
            `CIO_OP_DIA: io.rsp_rdata <= in_a;
            `CIO_OP_DIB: io.rsp_rdata <= in_b;
            `CIO_OP_DIC: io.rsp_rdata <= in_c;
            default: io.rsp_rdata <= 16'h0000;
         endcase
      end
   end

   // user-side data, load strobes and pulse
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         out_data <= 16'h0000;
         out_load <= 3'h0;
         dev_pulse <= 1'b0;
      end else if (ce) begin
         out_load <= 3'h0;
         dev_pulse <= addressed && io.io_op != `CIO_OP_SKP && io.io_func == `CIO_F_PULSE;
         if (addressed) begin
            out_data <= io.io_wdata;
            unique case (io.io_op)
               `CIO_OP_DOA: out_load <= 3'h1;
               `CIO_OP_DOB: out_load <= 3'h2;
               `CIO_OP_DOC: out_load <= 3'h4;
               default: out_load <= 3'h0;
            endcase
         end
      end
   end

   // request gated by this controller's mask bit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         io.irq_req <= 1'b0;
         io.irq_code <= `CIO_DEV_NONE;
      end else if (ce) begin
         io.irq_req <= dev_done && !io.io_mask[MIDX];
         io.irq_code <= (dev_done && !io.io_mask[MIDX]) ? DEV_CODE : `CIO_DEV_NONE;
      end
   end
endmodule : cio_ctl_end

/* File: rtl/cio_defines.svh */
// constants for the processor I/O control unit and its device controllers
// assumes 16-bit words, doc bit 0 is word bit 15
//
// Contract
// - skip tests device busy/done per t
// - device code 77 octal goes to cpu
// - status word bits 0-9 as listed
// - status bits 10-15: step, retained, memory, loop
// - status bit 6 shows halt routing strap
// - console ack clears console event bits
// - halt updates ion then stops processor
// - acknowledge returns code, upper bits ones
// - plain acknowledge keeps ion; general form updates
// - disable clears ion, enable sets ion
// - one more instruction after ion rises
// - one-cycle follower: two instructions first
// - device reset clears ion, busy, done
// - input c zeroes mask, ion per f
// - device reset at power-up, switch, console
// - device reset leaves float status untouched
// - mask write copies accumulator, ion per f
// - controller masks request when its bit set
// - controllers see mask, reset, acknowledge only
// - cpu skip tests ion or power flag
// - console register read, then ion per f
// - function field: none, start, clear, pulse
`ifndef CIO_DEFINES_SVH
`define CIO_DEFINES_SVH

`define CIO_DEV_CPU 6'h3F
`define CIO_DEV_NONE 6'h00

`define CIO_OP_NIO 3'h0
`define CIO_OP_DIA 3'h1
`define CIO_OP_DOA 3'h2
`define CIO_OP_DIB 3'h3
`define CIO_OP_DOB 3'h4
`define CIO_OP_DIC 3'h5
`define CIO_OP_DOC 3'h6
`define CIO_OP_SKP 3'h7

`define CIO_F_NONE 2'h0
`define CIO_F_START 2'h1
`define CIO_F_CLEAR 2'h2
`define CIO_F_PULSE 2'h3

`define CIO_T_BUSY_SET 2'h0
`define CIO_T_BUSY_CLR 2'h1
`define CIO_T_DONE_SET 2'h2
`define CIO_T_DONE_CLR 2'h3

`define CIO_W_AC_HI 12
`define CIO_W_AC_LO 11
`define CIO_W_OP_HI 10
`define CIO_W_OP_LO 8
`define CIO_W_F_HI 7
`define CIO_W_F_LO 6
`define CIO_W_DEV_HI 5
`define CIO_W_DEV_LO 0

`define CIO_ACK_FILL 10'h3FF
`define CIO_NODEV_DATA 16'hFFFF
`define CIO_MASK_RESET 16'h0000
`define CIO_IO_TIMEOUT 3'h4
`define CIO_NPIN 11

`endif

/* File: rtl/cio_if.sv */
// programmed I/O bus between processor and device controllers
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface cio_if;
   logic io_strobe;
   logic [2:0] io_op;
   logic [1:0] io_func;
   logic [5:0] io_dev;
   logic [15:0] io_wdata;
   logic io_reset;
   logic [15:0] io_mask;
   logic rsp_valid;
   logic rsp_busy;
   logic rsp_done;
   logic [15:0] rsp_rdata;
   logic irq_req;
   logic [5:0] irq_code;

   modport cpu (
      output io_strobe, io_op, io_func, io_dev, io_wdata, io_reset, io_mask,
      input rsp_valid, rsp_busy, rsp_done, rsp_rdata, irq_req, irq_code
   );

   modport ctl (
      input io_strobe, io_op, io_func, io_dev, io_wdata, io_reset, io_mask,
      output rsp_valid, rsp_busy, rsp_done, rsp_rdata, irq_req, irq_code
   );
endinterface : cio_if

/* File: rtl/cio_pkg.sv */
// types for the processor I/O control unit
// assumes cio_defines.svh for all numeric constants
package cio_pkg;

   typedef enum logic [0:0] {
      CIO_IDLE,
      CIO_WAIT
   } cio_bus_state_t;

   typedef enum logic [1:0] {
      CIO_DLY_OPEN,
      CIO_DLY_FIRST,
      CIO_DLY_SECOND
   } cio_delay_state_t;

endpackage : cio_pkg

/* File: verification/cio_props.sv */
// assertions on the programmed I/O bus between processor and controller
// assumes one clock domain; the bench instantiates it beside the bus
`timescale 1ns/100ps
`include "cio_defines.svh"
module cio_props #(
   parameter logic [5:0] DEV_CODE = 6'h0A,
   parameter int MASK_BIT = 14
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic io_strobe,
   input wire logic [2:0] io_op,
   input wire logic [1:0] io_func,
   input wire logic [5:0] io_dev,
   input wire logic [15:0] io_wdata,
   input wire logic io_reset,
   input wire logic [15:0] io_mask,
   input wire logic rsp_valid,
   input wire logic rsp_busy,
   input wire logic rsp_done,
   input wire logic [15:0] rsp_rdata,
   input wire logic irq_req,
   input wire logic [5:0] irq_code
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   property p_answer;
      io_strobe && io_dev == DEV_CODE |=> rsp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_cause;
      rsp_valid |-> $past(io_strobe);
   endproperty
   a_cause: assert property (p_cause) else $error("answer without strobe");
   property p_single;
      io_strobe && io_dev == DEV_CODE |=> !io_strobe;
   endproperty
   a_single: assert property (p_single) else $error("strobe too soon");
   property p_foreign;
      io_strobe && io_dev != DEV_CODE && io_op != `CIO_OP_DIC |=> !rsp_valid;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign answer");
   property p_masked;
      $past(io_mask[15-MASK_BIT]) && $past(io_mask[15-MASK_BIT], 2) |-> !irq_req;
   endproperty
   a_masked: assert property (p_masked) else $error("masked request");
   property p_code;
      irq_code == (irq_req ? DEV_CODE : 6'h00);
   endproperty
   a_code: assert property (p_code) else $error("bad request code");
   property p_reset;
      io_reset |-> ##2 !irq_req;
   endproperty
   a_reset: assert property (p_reset) else $error("request after reset");
   property p_mask_wr;
      io_strobe && io_dev == `CIO_DEV_CPU && io_op == `CIO_OP_DOB |-> ##[0:2] io_mask == io_wdata;
   endproperty
   a_mask_wr: assert property (p_mask_wr) else $error("mask not loaded");
   property p_mask_clr;
      io_strobe && io_dev == `CIO_DEV_CPU && io_op == `CIO_OP_DIC |-> ##[0:2] io_mask == 16'h0000;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("mask not zeroed");
endmodule : cio_props

/* File: verification/cpu_io_interrupt_control_tb_top.sv */
// bench: processor end and one controller joined by the I/O bus
// assumes the design sources and cio_defines.svh compile alongside
`timescale 1ns/100ps
`include "cio_defines.svh"
module cpu_io_interrupt_control_tb_top import cio_pkg::*;;
   localparam logic [5:0] DEV = 6'h0A;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic instr_valid, instr_start, start_interruptible, instr_retire, retire_one_cycle;
   logic vc_reset_cmd, halt_continue, dev_finish, reset_switch_pin, console_locked_pin;
   logic power_fail_pin, break_key_pin, load_key_pin, halt_strap_pin, single_step_pin;
   logic mem_retained_pin, loop_test_pin;
   logic [1:0] mem_size_pin;
   logic [15:0] instr_word, acc_in, vc_register, in_a, in_b, in_c, acc_out;
   logic instr_done, acc_write, skip_next, cpu_halted, console_entry, interrupt_allowed;
   logic dev_pulse, dev_busy, dev_done;
   int n_errors = 0;
   int check_count = 0;
   int n_reset_all_devices = 0, n_cons = 0, n_pulse = 0, n_allow = 0, cycles = 0;

   always #50 clk_sys = ~clk_sys;

   cio_if bus ();
   cio_cpu_end cio_cpu_end_inst (.clk_sys, .resetn, .ce, .io(bus.cpu), .instr_valid,
      .instr_word, .acc_in, .instr_start, .start_interruptible, .instr_retire,
      .retire_one_cycle, .vc_register, .vc_reset_cmd, .halt_continue, .power_fail_pin,
      .break_key_pin, .load_key_pin, .halt_strap_pin, .single_step_pin, .mem_retained_pin,
      .loop_test_pin, .mem_size_pin, .reset_switch_pin, .console_locked_pin, .instr_done,
      .acc_out, .acc_write, .skip_next, .cpu_halted, .console_entry, .interrupt_allowed);
   cio_ctl_end #(.DEV_CODE(DEV), .MASK_BIT(14)) cio_ctl_end_inst (.clk_sys, .resetn, .ce,
      .io(bus.ctl), .dev_finish, .in_a, .in_b, .in_c, .out_data(), .out_load(),
      .dev_pulse, .dev_busy, .dev_done);
   cio_props #(.DEV_CODE(DEV), .MASK_BIT(14)) cio_props_inst (.clk_sys, .resetn,
      .io_strobe(bus.io_strobe), .io_op(bus.io_op), .io_func(bus.io_func),
      .io_dev(bus.io_dev), .io_wdata(bus.io_wdata), .io_reset(bus.io_reset),
      .io_mask(bus.io_mask), .rsp_valid(bus.rsp_valid), .rsp_busy(bus.rsp_busy),
      .rsp_done(bus.rsp_done), .rsp_rdata(bus.rsp_rdata), .irq_req(bus.irq_req),
      .irq_code(bus.irq_code));

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (bus.io_reset === 1'b1) n_reset_all_devices <= n_reset_all_devices + 1;
      if (console_entry === 1'b1) n_cons <= n_cons + 1;
      if (dev_pulse === 1'b1) n_pulse <= n_pulse + 1;
      if (interrupt_allowed === 1'b1) n_allow <= n_allow + 1;
      if (cycles == 3000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   // done is looked at in the cycle it pulses
   task automatic op(input logic [1:0] ac, input logic [2:0] o, input logic [1:0] f,
         input logic [5:0] d, input int lat);
      @(posedge clk_sys) instr_valid <= 1'b1;
      instr_word <= {3'h3, ac, o, f, d};
      repeat (lat) @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1 chk(16'(instr_done), 16'h1);
   endtask : op

   task automatic st(input logic [15:0] m, input logic [15:0] exp);
      op(2'h1, `CIO_OP_SKP, `CIO_F_NONE, `CIO_DEV_CPU, 1);
      chk(acc_out & m, exp);
   endtask : st

   task automatic skips(input logic [5:0] d, input int lat, input logic [3:0] exp);
      for (int t = 0; t < 4; t++) begin
         op(2'h0, `CIO_OP_SKP, 2'(t), d, lat);
         chk(16'(skip_next), 16'(exp[t]));
      end
   endtask : skips

   task automatic t_reset;
      cyc(4);
      chk(16'(n_reset_all_devices), 16'h1);
      st(16'hFFFF, 16'h2800);
      op(2'h0, `CIO_OP_DOA, `CIO_F_PULSE, `CIO_DEV_CPU, 1);
      st(16'hFFFF, 16'h2000);
   endtask : t_reset

   task automatic t_pins;
      @(posedge clk_sys) {power_fail_pin, break_key_pin, load_key_pin, halt_strap_pin} <= 4'hF;
      {single_step_pin, mem_retained_pin, loop_test_pin} <= 3'h7;
      cyc(3);
      @(posedge clk_sys) break_key_pin <= 1'b0;
      for (int m = 1; m < 4; m++) begin
         @(posedge clk_sys) mem_size_pin <= 2'(m);
         cyc(3);
         st(16'hFFFF, 16'hB2B1 | 16'(m << 2));
      end
      op(2'h0, `CIO_OP_DOA, `CIO_F_PULSE, `CIO_DEV_CPU, 1);
      st(16'hFFFF, 16'hA2BD);
      skips(`CIO_DEV_CPU, 1, 4'b0110);
      op(2'h0, `CIO_OP_NIO, `CIO_F_START, `CIO_DEV_CPU, 1);
      skips(`CIO_DEV_CPU, 1, 4'b0101);
      op(2'h0, `CIO_OP_NIO, `CIO_F_CLEAR, `CIO_DEV_CPU, 1);
      st(16'h4000, 16'h0000);
   endtask : t_pins

   task automatic t_device;
      op(2'h0, `CIO_OP_DOA, `CIO_F_START, DEV, 3);
      chk({14'h0, dev_busy, dev_done}, 16'h2);
      skips(DEV, 3, 4'b1001);
      op(2'h0, `CIO_OP_NIO, `CIO_F_CLEAR, DEV, 3);
      chk({14'h0, dev_busy, dev_done}, 16'h0);
      op(2'h0, `CIO_OP_NIO, `CIO_F_PULSE, DEV, 3);
      chk(16'(n_pulse), 16'h1);
      @(posedge clk_sys) dev_finish <= 1'b1;
      @(posedge clk_sys) dev_finish <= 1'b0;
      cyc(2);
      skips(DEV, 3, 4'b0110);
      op(2'h1, `CIO_OP_DIB, `CIO_F_NONE, `CIO_DEV_CPU, 1);
      chk(acc_out, {10'h3FF, DEV});
      op(2'h1, `CIO_OP_DIB, `CIO_F_START, `CIO_DEV_CPU, 1);
      op(2'h1, `CIO_OP_DIB, `CIO_F_NONE, `CIO_DEV_CPU, 1);
      st(16'h4100, 16'h4100);
      @(posedge clk_sys) acc_in <= 16'hFFFF;
      op(2'h1, `CIO_OP_DOB, `CIO_F_CLEAR, `CIO_DEV_CPU, 1);
      chk(16'(acc_write), 16'h0);
      cyc(2);
      chk(bus.io_mask, 16'hFFFF);
      st(16'h4100, 16'h0000);
      op(2'h1, `CIO_OP_DIC, `CIO_F_START, `CIO_DEV_CPU, 1);
      chk(16'(acc_write), 16'h0);
      cyc(2);
      chk(bus.io_mask, 16'h0000);
      chk({14'h0, dev_busy, dev_done}, 16'h0);
      st(16'h4000, 16'h4000);
      op(2'h0, `CIO_OP_DIC, `CIO_F_CLEAR, `CIO_DEV_CPU, 1);
      st(16'h4000, 16'h0000);
   endtask : t_device

   task automatic t_delay;
      int a;
      @(posedge clk_sys) dev_finish <= 1'b1;
      @(posedge clk_sys) dev_finish <= 1'b0;
      op(2'h0, `CIO_OP_NIO, `CIO_F_START, `CIO_DEV_CPU, 1);
      cyc(3);
      chk(16'(interrupt_allowed), 16'h0);
      @(posedge clk_sys) {instr_retire, retire_one_cycle} <= 2'h3;
      @(posedge clk_sys) {instr_retire, retire_one_cycle} <= 2'h0;
      cyc(2);
      chk(16'(interrupt_allowed), 16'h0);
      @(posedge clk_sys) instr_retire <= 1'b1;
      @(posedge clk_sys) instr_retire <= 1'b0;
      cyc(2);
      chk(16'(interrupt_allowed), 16'h1);
      op(2'h0, `CIO_OP_NIO, `CIO_F_CLEAR, `CIO_DEV_CPU, 1);
      cyc(2);
      chk(16'(interrupt_allowed), 16'h0);
      op(2'h0, `CIO_OP_NIO, `CIO_F_START, `CIO_DEV_CPU, 1);
      a = n_allow;
      @(posedge clk_sys) {instr_start, start_interruptible} <= 2'h3;
      @(posedge clk_sys) {instr_start, start_interruptible} <= 2'h0;
      cyc(3);
      chk(16'(n_allow > a), 16'h1);
   endtask : t_delay

   task automatic t_halt;
      int a;
      @(posedge clk_sys) {instr_retire, halt_strap_pin} <= 2'h2;
      @(posedge clk_sys) instr_retire <= 1'b0;
      cyc(3);
      chk(16'(interrupt_allowed), 16'h1);
      op(2'h0, `CIO_OP_DOC, `CIO_F_NONE, `CIO_DEV_CPU, 1);
      cyc(2);
      chk({14'h0, cpu_halted, interrupt_allowed}, 16'h2);
      @(posedge clk_sys) halt_continue <= 1'b1;
      @(posedge clk_sys) halt_continue <= 1'b0;
      cyc(2);
      chk(16'(cpu_halted), 16'h0);
      st(16'h4400, 16'h4400);
      @(posedge clk_sys) halt_strap_pin <= 1'b1;
      cyc(3);
      a = n_cons;
      op(2'h0, `CIO_OP_DOC, `CIO_F_CLEAR, `CIO_DEV_CPU, 1);
      cyc(2);
      chk(16'(cpu_halted), 16'h0);
      chk(16'(n_cons - a), 16'h1);
      st(16'h4000, 16'h0000);
   endtask : t_halt

   task automatic t_misc;
      int a;
      @(posedge clk_sys) vc_register <= 16'h5A3C;
      op(2'h1, `CIO_OP_DIA, `CIO_F_START, `CIO_DEV_CPU, 1);
      chk(acc_out, 16'h5A3C);
      st(16'h4000, 16'h4000);
      op(2'h1, `CIO_OP_DIA, `CIO_F_NONE, 6'h05, 6);
      chk(acc_out, `CIO_NODEV_DATA);
      a = n_reset_all_devices;
      @(posedge clk_sys) {console_locked_pin, reset_switch_pin} <= 2'h3;
      cyc(4);
      @(posedge clk_sys) reset_switch_pin <= 1'b0;
      cyc(4);
      chk(16'(n_reset_all_devices - a), 16'h0);
      @(posedge clk_sys) {console_locked_pin, reset_switch_pin} <= 2'h1;
      cyc(6);
      chk(16'(n_reset_all_devices - a), 16'h1);
      st(16'h4000, 16'h0000);
      @(posedge clk_sys) {vc_reset_cmd, reset_switch_pin} <= 2'h2;
      @(posedge clk_sys) vc_reset_cmd <= 1'b0;
      cyc(3);
      chk(16'(n_reset_all_devices - a), 16'h2);
   endtask : t_misc

   initial begin
      {instr_valid, instr_start, start_interruptible, instr_retire, retire_one_cycle} = '0;
      {vc_reset_cmd, halt_continue, dev_finish, reset_switch_pin, console_locked_pin} = '0;
      {power_fail_pin, break_key_pin, load_key_pin, halt_strap_pin, single_step_pin} = '0;
      {mem_retained_pin, loop_test_pin, mem_size_pin} = '0;
      {instr_word, acc_in, vc_register, in_a, in_b, in_c} = '0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_pins();
      t_device();
      t_delay();
      t_halt();
      t_misc();
      test_done();
   end
endmodule : cpu_io_interrupt_control_tb_top
